//--- cab_alu_branch.sv
`timescale 1ns/1ps
// Behaviour
// - Multiply index by accumulator, 11 cycles, 0x42
// - Add operand plus carry into accumulator
// - Subtract operand and borrow from accumulator
// - Exclusive-or operand into accumulator
// - Compare sets flags, accumulator kept
// - Bit test ANDs for flags only
// - 0x22 higher, 0x23 lower or same
// - 0x24 carry clear, 0x25 carry set
// - 0x28/0x29 on half-carry clear/set
// - 0x2C/0x2D on interrupt mask clear/set
// - 0x2E/0x2F on interrupt pin low/high
module cab_alu_branch
    import cab_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       instValid,
    output logic            instReady,
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] operand,
    input  wire logic       flagLoad,
    input  cab_flags_t      flagIn,
    input  wire logic       irqPin,
    input  wire logic       idxLoad,
    output logic [7:0]      accOut,
    output logic [7:0]      idxOut,
    output cab_flags_t      flagsOut,
    output logic            branchTaken,
    output logic            instDone,
    output logic [1:0]      instBytes,
    output logic            illegalOp
);
    cab_dec_t   dec;
    logic [7:0] acc_q;
    logic [7:0] idx_q;
    cab_flags_t flags_q;
    logic [3:0] cnt_q;
    logic       busy_q;
    cab_op_t    op_q;
    logic [7:0] opc_q;
    logic [7:0] opnd_q;
    logic       irqMeta_q;
    logic       irqSync_q;
    logic       take;
    logic       cond;
    logic       finish;
    logic [8:0] sum;
    logic [4:0] lowSum;
    logic [7:0] res;
    logic [15:0] prod;
    logic [1:0] bytes_q;
    logic       taken_q;
    logic       done_q;
    logic       illegal_q;

    cab_decoder u_dec
    (
        .opcode (opcode),
        .dec    (dec)
    );

    assign instReady = !busy_q;
    assign take      = instValid && !busy_q;
    assign finish    = busy_q && (cnt_q == 4'd1);

    // Pin is asynchronous to the core clock
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            irqMeta_q <= 1'b1;
            irqSync_q <= 1'b1;
        end
        else
        begin
            irqMeta_q <= irqPin;
            irqSync_q <= irqMeta_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            busy_q  <= 1'b0;
            cnt_q   <= 4'd0;
            op_q    <= CAB_NONE;
            opc_q   <= 8'h00;
            opnd_q  <= 8'h00;
            bytes_q <= 2'd1;
        end
        else if (take)
        begin
            busy_q  <= 1'b1;
            cnt_q   <= dec.cycles;
            op_q    <= dec.op;
            opc_q   <= opcode;
            opnd_q  <= operand;
            bytes_q <= dec.bytes;
        end
        else if (finish)
        begin
            busy_q <= 1'b0;
            cnt_q  <= 4'd0;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - 4'd1;
        end
    end

    // Branch condition uses flags as held when the branch completes
    always_comb
    begin
        case (opc_q[3:1])
            3'd0:    cond = 1'b1;
            3'd1:    cond = !(flags_q.carry || flags_q.zero);
            3'd2:    cond = !flags_q.carry;
            3'd3:    cond = !flags_q.zero;
            3'd4:    cond = !flags_q.nibbleCarry;
            3'd5:    cond = !flags_q.negative;
            3'd6:    cond = !flags_q.irqMask;
            default: cond = !irqSync_q;
        endcase
        if (opc_q[0])
        begin
            cond = !cond;
        end
    end

    assign prod   = idx_q * acc_q;
    assign sum    = (op_q == CAB_ADC) ? ({1'b0, acc_q} + {1'b0, opnd_q} + {8'h00, flags_q.carry})
                  : ({1'b0, acc_q} - {1'b0, opnd_q}
                     - {8'h00, (op_q == CAB_SUBB) && flags_q.carry});
    assign lowSum = {1'b0, acc_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, flags_q.carry};

    always_comb
    begin
        case (op_q)
            CAB_XOR: res = acc_q ^ opnd_q;
            CAB_BIT: res = acc_q & opnd_q;
            default: res = sum[7:0];
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            acc_q <= RST_ACC;
            idx_q <= RST_IDX;
        end
        else if (finish)
        begin
            case (op_q)
                CAB_UMULT:
                begin
                    idx_q <= prod[15:8];
                    acc_q <= prod[7:0];
                end
                CAB_ADC, CAB_SUBB, CAB_XOR: acc_q <= res;
                default: acc_q <= acc_q;
            endcase
        end
        // Index loaders lie outside this block; without this a multiply only ever sees zero
        else if (idxLoad && !busy_q)
        begin
            idx_q <= operand;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            flags_q <= '{nibbleCarry: 1'b0, irqMask: RST_MASK, negative: 1'b0,
                         zero: 1'b0, carry: 1'b0};
        end
        else if (finish)
        begin
            case (op_q)
                CAB_UMULT:
                begin
                    flags_q.nibbleCarry <= 1'b0;
                    flags_q.carry       <= 1'b0;
                end
                CAB_ADC:
                begin
                    flags_q.nibbleCarry <= lowSum[4];
                    flags_q.negative    <= res[7];
                    flags_q.zero        <= (res == 8'h00);
                    flags_q.carry       <= sum[8];
                end
                CAB_SUBB, CAB_COMPARE:
                begin
                    flags_q.negative <= res[7];
                    flags_q.zero     <= (res == 8'h00);
                    flags_q.carry    <= sum[8];
                end
                CAB_XOR, CAB_BIT:
                begin
                    flags_q.negative <= res[7];
                    flags_q.zero     <= (res == 8'h00);
                end
                default: flags_q <= flags_q;
            endcase
        end
        else if (flagLoad && !busy_q)
        begin
            flags_q <= flagIn;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            taken_q   <= 1'b0;
            done_q    <= 1'b0;
            illegal_q <= 1'b0;
        end
        else
        begin
            done_q    <= finish;
            taken_q   <= finish && ((op_q == CAB_CALL) || ((op_q == CAB_BRANCH) && cond));
            illegal_q <= take && !dec.known;
        end
    end

    assign accOut      = acc_q;
    assign idxOut      = idx_q;
    assign flagsOut    = flags_q;
    assign branchTaken = taken_q;
    assign instDone    = done_q;
    assign instBytes   = bytes_q;
    assign illegalOp   = illegal_q;

    // Ages a multiply from its take edge, so an early completion shows up
    logic [3:0] multAge_q;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            multAge_q <= 4'd0;
        end
        else if (take && opcode == OP_UMULT)
        begin
            multAge_q <= 4'd1;
        end
        else if (multAge_q != 4'd0 && multAge_q != CYC_UMULT)
        begin
            multAge_q <= multAge_q + 4'd1;
        end
        else
        begin
            multAge_q <= 4'd0;
        end
    end

    // Result shows in the cycle after the eleventh edge past the take
    property p_umult_cycles;
        @(posedge mclk) disable iff (sys_rst)
        (take && opcode == OP_UMULT) |-> ##12 instDone;
    endproperty
    a_umult_cycles: assert property (p_umult_cycles) else $error("multiply length wrong");

    property p_umult_quiet;
        @(posedge mclk) disable iff (sys_rst)
        (multAge_q != 4'd0) |-> !instDone;
    endproperty
    a_umult_quiet: assert property (p_umult_quiet) else $error("multiply ended early");

    property p_umult_flags;
        @(posedge mclk) disable iff (sys_rst)
        (finish && op_q == CAB_UMULT) |=> !flagsOut.carry && !flagsOut.nibbleCarry
            && flagsOut.zero == $past(flags_q.zero) && flagsOut.irqMask == $past(flags_q.irqMask)
            && flagsOut.negative == $past(flags_q.negative);
    endproperty
    a_umult_flags: assert property (p_umult_flags) else $error("multiply flags wrong");

    property p_adc_imm;
        @(posedge mclk) disable iff (sys_rst)
        (take && opcode == 8'ha9) |-> ##3 instDone && accOut == $past(acc_q, 3) + $past(operand, 3)
            + {7'h00, $past(flags_q.carry, 3)};
    endproperty
    a_adc_imm: assert property (p_adc_imm) else $error("add with carry wrong");

    property p_cmp_keep;
        @(posedge mclk) disable iff (sys_rst)
        (finish && (op_q == CAB_COMPARE || op_q == CAB_BIT)) |=> $stable(accOut);
    endproperty
    a_cmp_keep: assert property (p_cmp_keep) else $error("compare changed acc");

    property p_eor;
        @(posedge mclk) disable iff (sys_rst)
        (finish && op_q == CAB_XOR) |=> accOut == ($past(acc_q) ^ $past(opnd_q));
    endproperty
    a_eor: assert property (p_eor) else $error("exclusive or wrong");

    property p_branch_len;
        @(posedge mclk) disable iff (sys_rst)
        (take && opcode[7:4] == HI_BRANCH) |-> ##1 (!instDone)[*3]
            ##1 (instDone && instBytes == 2'd2);
    endproperty
    a_branch_len: assert property (p_branch_len) else $error("branch length wrong");

    property p_never;
        @(posedge mclk) disable iff (sys_rst)
        (finish && op_q == CAB_BRANCH && opc_q == 8'h21) |=> !branchTaken;
    endproperty
    a_never: assert property (p_never) else $error("branch never taken");

    property p_carry_branch;
        @(posedge mclk) disable iff (sys_rst)
        (finish && op_q == CAB_BRANCH && opc_q == 8'h25) |=> branchTaken == $past(flags_q.carry);
    endproperty
    a_carry_branch: assert property (p_carry_branch) else $error("carry branch wrong");

    property p_pin_branch;
        @(posedge mclk) disable iff (sys_rst)
        (finish && op_q == CAB_BRANCH && opc_q == 8'h2f) |=> branchTaken == $past(irqSync_q);
    endproperty
    a_pin_branch: assert property (p_pin_branch) else $error("pin branch wrong");

    property p_call;
        @(posedge mclk) disable iff (sys_rst)
        (take && opcode == OP_CALL) |-> ##7 instDone && branchTaken;
    endproperty
    a_call: assert property (p_call) else $error("call wrong");

    c_umult: cover property (@(posedge mclk) disable iff (sys_rst) finish && op_q == CAB_UMULT);
    c_taken: cover property (@(posedge mclk) disable iff (sys_rst) branchTaken);
    c_subb: cover property (@(posedge mclk) disable iff (sys_rst) finish && op_q == CAB_SUBB);
endmodule : cab_alu_branch

//--- cab_decoder.sv
`timescale 1ns/1ps
module cab_decoder
    import cab_pkg::*;
(
    input  wire logic [7:0] opcode,
    output cab_dec_t        dec
);
    logic [3:0] hiNib;
    logic [3:0] loNib;
    assign hiNib = opcode[7:4];
    assign loNib = opcode[3:0];

    always_comb
    begin
        dec = '{op: CAB_NONE, bytes: 2'd1, cycles: 4'd1, known: 1'b0};
        if (opcode == OP_UMULT)
        begin
            dec = '{op: CAB_UMULT, bytes: 2'd1, cycles: CYC_UMULT, known: 1'b1};
        end
        else if (opcode == OP_CALL)
        begin
            dec = '{op: CAB_CALL, bytes: 2'd2, cycles: CYC_CALL, known: 1'b1};
        end
        else if (hiNib == HI_BRANCH)
        begin
            dec = '{op: CAB_BRANCH, bytes: 2'd2, cycles: CYC_BRANCH, known: 1'b1};
        end
        else if (hiNib >= HI_IMM)
        begin
            case (loNib)
                LO_ADC:     dec.op = CAB_ADC;
                LO_SUBB:    dec.op = CAB_SUBB;
                LO_XOR:     dec.op = CAB_XOR;
                LO_COMPARE: dec.op = CAB_COMPARE;
                LO_BIT:     dec.op = CAB_BIT;
                default:    dec.op = CAB_NONE;
            endcase
            dec.known = (dec.op != CAB_NONE);
            case (hiNib)
                HI_IMM:
                begin
                    dec.bytes  = 2'd2;
                    dec.cycles = CYC_IMM;
                end
                HI_DIR:
                begin
                    dec.bytes  = 2'd2;
                    dec.cycles = CYC_DIR;
                end
                HI_EXT:
                begin
                    dec.bytes  = 2'd3;
                    dec.cycles = CYC_EXT;
                end
                HI_IX2:
                begin
                    dec.bytes  = 2'd3;
                    dec.cycles = CYC_IX2;
                end
                HI_IX1:
                begin
                    dec.bytes  = 2'd2;
                    dec.cycles = CYC_IX1;
                end
                default:
                begin
                    dec.bytes  = 2'd1;
                    dec.cycles = CYC_IX;
                end
            endcase
            if (!dec.known)
            begin
                dec.bytes  = 2'd1;
                dec.cycles = 4'd1;
            end
        end
    end
endmodule : cab_decoder

//--- cab_pkg.sv
package cab_pkg;

    localparam logic [7:0] OP_UMULT    = 8'h42;
    localparam logic [7:0] OP_CALL     = 8'had;
    localparam logic [3:0] LO_ADC      = 4'h9;
    localparam logic [3:0] LO_SUBB     = 4'h2;
    localparam logic [3:0] LO_XOR      = 4'h8;
    localparam logic [3:0] LO_COMPARE  = 4'h1;
    localparam logic [3:0] LO_BIT      = 4'h5;
    localparam logic [3:0] HI_IMM      = 4'ha;
    localparam logic [3:0] HI_DIR      = 4'hb;
    localparam logic [3:0] HI_EXT      = 4'hc;
    localparam logic [3:0] HI_IX2      = 4'hd;
    localparam logic [3:0] HI_IX1      = 4'he;
    localparam logic [3:0] HI_IX       = 4'hf;
    localparam logic [3:0] HI_BRANCH   = 4'h2;
    localparam logic [3:0] CYC_UMULT   = 4'd11;
    localparam logic [3:0] CYC_IMM     = 4'd2;
    localparam logic [3:0] CYC_DIR     = 4'd3;
    localparam logic [3:0] CYC_EXT     = 4'd4;
    localparam logic [3:0] CYC_IX      = 4'd3;
    localparam logic [3:0] CYC_IX1     = 4'd4;
    localparam logic [3:0] CYC_IX2     = 4'd5;
    localparam logic [3:0] CYC_BRANCH  = 4'd3;
    localparam logic [3:0] CYC_CALL    = 4'd6;
    localparam logic [7:0] RST_ACC     = 8'h00;
    localparam logic [7:0] RST_IDX     = 8'h00;
    localparam logic       RST_MASK    = 1'b1;

    typedef struct packed {
        logic nibbleCarry;
        logic irqMask;
        logic negative;
        logic zero;
        logic carry;
    } cab_flags_t;

    typedef enum logic [3:0] {
        CAB_NONE,
        CAB_UMULT,
        CAB_ADC,
        CAB_SUBB,
        CAB_XOR,
        CAB_COMPARE,
        CAB_BIT,
        CAB_BRANCH,
        CAB_CALL
    } cab_op_t;

    typedef struct packed {
        cab_op_t    op;
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic       known;
    } cab_dec_t;

endpackage : cab_pkg

//--- tb_cab_alu_branch.sv
`timescale 1ns/1ps
module tb_cab_alu_branch
    import cab_pkg::*;
;
    logic       mclk      = 1'b0;
    logic       sys_rst   = 1'b1;
    logic       instValid = 1'b0;
    logic       flagLoad  = 1'b0;
    logic       irqPin    = 1'b1;
    logic       idxLoad   = 1'b0;
    logic [7:0] opcode    = 8'h00;
    logic [7:0] operand   = 8'h00;
    cab_flags_t flagIn    = '0;
    logic       instReady;
    logic       instDone;
    logic       branchTaken;
    logic       illegalOp;
    logic [7:0] accOut;
    logic [7:0] idxOut;
    logic [1:0] instBytes;
    cab_flags_t flagsOut;
    logic [7:0] eAcc;
    logic [7:0] eIdx;
    cab_flags_t eFlg;
    int         failures   = 0;
    int         checkCount = 0;
    logic [3:0] hiTab  [6] = '{4'ha, 4'hb, 4'hc, 4'hf, 4'he, 4'hd};
    int         cycTab [6] = '{2, 3, 4, 3, 4, 5};
    logic [1:0] bytTab [6] = '{2'd2, 2'd2, 2'd3, 2'd1, 2'd2, 2'd3};
    logic [3:0] loTab  [5] = '{4'h9, 4'h2, 4'h8, 4'h1, 4'h5};
    logic [7:0] mTab   [6] = '{8'h01, 8'hff, 8'h7f, 8'h80, 8'h0f, 8'h00};

    always #50 mclk = ~mclk;

    cab_alu_branch DUT (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .instValid   (instValid),
        .instReady   (instReady),
        .opcode      (opcode),
        .operand     (operand),
        .flagLoad    (flagLoad),
        .flagIn      (flagIn),
        .irqPin      (irqPin),
        .idxLoad     (idxLoad),
        .accOut      (accOut),
        .idxOut      (idxOut),
        .flagsOut    (flagsOut),
        .branchTaken (branchTaken),
        .instDone    (instDone),
        .instBytes   (instBytes),
        .illegalOp   (illegalOp)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checkCount++;
        if (got !== exp)
        begin
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
            failures++;
        end
    endtask : chk

    task end_of_test;
        if (failures == 0 && checkCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // Branch condition; odd opcodes test the opposite sense of the even one
    function automatic logic taken(input logic [7:0] op);
        logic c;
        case (op[3:1])
            3'd0:    c = 1'b1;
            3'd1:    c = ~(eFlg.carry | eFlg.zero);
            3'd2:    c = ~eFlg.carry;
            3'd3:    c = ~eFlg.zero;
            3'd4:    c = ~eFlg.nibbleCarry;
            3'd5:    c = ~eFlg.negative;
            3'd6:    c = ~eFlg.irqMask;
            default: c = ~irqPin;
        endcase
        return c ^ op[0];
    endfunction : taken

    task automatic model(input logic [7:0] op, input logic [7:0] m);
        logic [8:0]  r;
        logic [15:0] p;
        if (op == 8'h42)
        begin
            p = eIdx * eAcc;
            {eIdx, eAcc} = p;
            eFlg.nibbleCarry = 1'b0;
            eFlg.carry = 1'b0;
            return;
        end
        r = {1'b0, eAcc & m};
        case (op[3:0])
            4'h9:
            begin
                r = eAcc + m + eFlg.carry;
                eFlg.nibbleCarry = ({1'b0, eAcc[3:0]} + m[3:0] + eFlg.carry) > 5'h0f;
            end
            4'h2:    r = eAcc - m - eFlg.carry;
            4'h1:    r = eAcc - m;
            4'h8:    r = {1'b0, eAcc ^ m};
            default: ;
        endcase
        if (op[3:0] != 4'h8 && op[3:0] != 4'h5)
            eFlg.carry = r[8];
        eFlg.negative = r[7];
        eFlg.zero = (r[7:0] == 8'h00);
        if (op[3:0] == 4'h9 || op[3:0] == 4'h2 || op[3:0] == 4'h8)
            eAcc = r[7:0];
    endtask : model

    // Called at a falling edge; returns at the falling edge where the result shows
    task automatic run(input logic [7:0] op, input logic [7:0] m, input int cyc,
                       input logic [1:0] byt);
        int   k;
        logic tk;
        tk = (op == 8'had) || (op[7:4] == 4'h2 && taken(op));
        if (op[7:4] != 4'h2 && op != 8'had)
            model(op, m);
        opcode = op;
        operand = m;
        instValid = 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        instValid = 1'b0;
        k = 0;
        while (instDone !== 1'b1 && k < 20)
        begin
            chk(instReady, 1'b0, "ready while busy");
            @(negedge mclk);
            k++;
        end
        chk(16'(k), 16'(cyc), "cycle count");
        chk(branchTaken, tk, "branch taken");
        chk(instBytes, byt, "byte count");
        chk(illegalOp, 1'b0, "illegal flag");
        chk(accOut, eAcc, "accumulator");
        chk(idxOut, eIdx, "index");
        chk(flagsOut, eFlg, "flags");
    endtask : run

    task automatic loadFlags(input cab_flags_t f);
        @(negedge mclk);
        flagIn = f;
        flagLoad = 1'b1;
        @(negedge mclk);
        flagLoad = 1'b0;
        eFlg = f;
        chk(flagsOut, f, "flag load");
    endtask : loadFlags

    task automatic loadIdx(input logic [7:0] v);
        @(negedge mclk);
        operand = v;
        idxLoad = 1'b1;
        @(negedge mclk);
        idxLoad = 1'b0;
        eIdx = v;
        chk(idxOut, v, "index load");
    endtask : loadIdx

    task automatic t_reset;
        eAcc = 8'h00;
        eIdx = 8'h00;
        eFlg = '0;
        eFlg.irqMask = 1'b1;
        chk({accOut, idxOut}, {eAcc, eIdx}, "reset regs");
        chk(flagsOut, eFlg, "reset flags");
        chk({instReady, instDone, branchTaken}, 3'b100, "reset outputs");
    endtask : t_reset

    task automatic t_umult;
        loadFlags(5'h1f);
        run(8'ha8, eAcc ^ 8'hc3, 2, 2'd2);
        loadIdx(8'h5a);
        run(8'h42, 8'h55, 11, 2'd1);
        loadFlags(5'h1e);
        run(8'h42, 8'h00, 11, 2'd1);
    endtask : t_umult

    task automatic t_group;
        for (int i = 0; i < 5; i++)
            for (int j = 0; j < 6; j++)
            begin
                loadFlags({4'h0, j[0]});
                run({hiTab[j], loTab[i]}, mTab[j], cycTab[j], bytTab[j]);
                run({hiTab[j], loTab[i]}, mTab[5 - j], cycTab[j], bytTab[j]);
            end
    endtask : t_group

    // Flag patterns split carry from zero so both unsigned-higher outcomes show
    task automatic t_branch;
        cab_flags_t pat [7] = '{5'h00, 5'h1f, 5'h01, 5'h02, 5'h10, 5'h08, 5'h04};
        for (int p = 0; p < 7; p++)
        begin
            loadFlags(pat[p]);
            for (int op = 8'h20; op <= 8'h2d; op++)
                run(op[7:0], 8'h00, 3, 2'd2);
        end
        run(8'had, 8'h10, 6, 2'd2);
    endtask : t_branch

    // Pin passes a two-stage synchroniser, so settle it before branching
    task automatic t_pin;
        for (int lvl = 0; lvl < 2; lvl++)
        begin
            irqPin = lvl[0];
            repeat (3) @(negedge mclk);
            run(8'h2e, 8'h00, 3, 2'd2);
            run(8'h2f, 8'h00, 3, 2'd2);
        end
    endtask : t_pin

    task automatic t_illegal;
        logic seen;
        seen = 1'b0;
        opcode = 8'h9d;
        instValid = 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        instValid = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            seen |= (illegalOp === 1'b1);
            @(negedge mclk);
        end
        chk(seen, 1'b1, "illegal pulse");
        chk({accOut, idxOut}, {eAcc, eIdx}, "illegal regs");
        chk({flagsOut, instReady}, {eFlg, 1'b1}, "illegal flags");
    endtask : t_illegal

    initial
    begin
        #2_000_000;
        $display("[ERR] %0t watchdog expired", $time);
        failures++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_umult();
        t_group();
        t_branch();
        t_pin();
        t_illegal();
        end_of_test();
    end

endmodule : tb_cab_alu_branch
